// File: verilog/transport_pkg.sv
// Shared constants, types and mode table of the converter transmit link
`default_nettype none
package transport_pkg;
  // Control characters (octet value before line coding)
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;
  // Sync header of a data block
  localparam logic [1:0] SH_DATA = 2'h1;
  // Register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_KLEN = 12'h008;
  // Control register fields
  localparam int C_MODE = 0;
  localparam int C_SCR = 2;
  localparam int C_NCO = 3;
  localparam int C_FEC = 4;
  localparam int C_RESTART = 5;
  // Status register fields
  localparam int S_SREF = 3;
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] KLEN_RST = 8'h1f;
  // Framing counts
  localparam logic [2:0] BLK_LAST = 3'h7;
  localparam logic [4:0] MB_LAST = 5'h1f;
  localparam logic [1:0] ILAS_LAST = 2'h3;
  localparam logic [2:0] CGS_NEED = 3'h4;
  localparam logic [2:0] LOCK_NEED = 3'h4;
  localparam int SAMPLE_W = 12;

  typedef enum logic [1:0] {
    ST_CGS  = 2'b00,
    ST_WAIT = 2'b01,
    ST_ILAS = 2'b10,
    ST_DATA = 2'b11
  } link_state_t;

  // Mode bit 1 selects 64b/66b; mode bit 0 selects two octets per frame
  function automatic logic mode_is64(input logic [1:0] m);
    return m[1];
  endfunction : mode_is64

  function automatic logic [1:0] mode_f(input logic [1:0] m);
    return m[0] ? 2'h2 : 2'h1;
  endfunction : mode_f
endpackage : transport_pkg
`default_nettype wire

// File: verilog/conv_link_if.sv
// Link between the transmitting converter end and the receiving logic end
`default_nettype none
interface conv_link_if #(parameter int LANES = 2);
  logic               sync_n;
  logic [LANES*8-1:0] octet;
  logic [LANES-1:0]   ctrl_k;
  logic [1:0]         sync_hdr;
  logic               hdr_valid;

  modport tx (input sync_n, output octet, output ctrl_k, output sync_hdr, output hdr_valid);
  modport rx (output sync_n, input octet, input ctrl_k, input sync_hdr, input hdr_valid);
endinterface : conv_link_if
`default_nettype wire

// File: verilog/link_scrambler.sv
// Self-synchronous octet-wide scrambler and descrambler for both line codes
`default_nettype none
module link_scrambler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       mode64,
  input  wire logic       descramble,
  input  wire logic       enable,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  logic [57:0] state_r;
  logic [57:0] state_nxt;
  logic [7:0]  mixed;

  // Bit-serial over the octet, MSB first; 64b blocks are just eight octets in a row
  function automatic logic [65:0] step(input logic [57:0] s, input logic [7:0] d,
                                       input logic m64, input logic dsc);
    logic [57:0] st;
    logic [7:0]  y;
    logic        fb;
    st = s;
    y  = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      fb   = m64 ? (st[57] ^ st[38]) : (st[14] ^ st[13]);
      y[i] = d[i] ^ fb;
      st   = {st[56:0], dsc ? d[i] : y[i]};
    end
    return {st, y};
  endfunction : step

  assign {state_nxt, mixed} = step(state_r, din, mode64, descramble);
  assign dout = enable ? mixed : din;

  // State only advances while enabled (scrambling or descrambling), cleared on restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else if (clear) begin
      state_r <= '0;
    end else if (enable) begin
      state_r <= state_nxt;
    end
  end
endmodule : link_scrambler
`default_nettype wire

// File: verilog/tx_transport_end.sv
// Converter transmit end: transport mapping, scrambling and link framing
// Operation
// - 64b/66b block sync never needs sync request
// - Every 64b/66b block carries sync header
// - Receiver pulls sync low to begin CGS
// - Sync ignored in 64b/66b except oscillator sync
// - SYSREF resets multiframe/extended multiblock counters
// - One device clock runs all logic
// - FEC available only with 64b/66b
// - No CRC3, no command channel in header
// - Lanes of one link aligned together
// - Physical sync input in 8b/10b
// - Samples packed into octets, N' bits each
// - F octets per frame, S samples, L lanes
// - One mode setting picks whole mapping
// - Scrambling optional 8b/10b, forced 64b/66b
// - 8b/10b scrambles each octet
// - 64b/66b scrambles block before header
// - Alignment sequence always sent unscrambled
// - Different polynomial per line code
// - Receiver descrambler self-synchronizes
// - Frames grouped into multiframes or multiblocks
// - Commas on all lanes while sync low
// - Alignment sequence starts at next LMFC
//
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
module tx_transport_end #(
  parameter int LANES   = 2,
  parameter int EMB_LEN = 1
) (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [11:0]                            paddr,
  input  wire logic [31:0]                            pwdata,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   sysref,
  input  wire logic [LANES*transport_pkg::SAMPLE_W-1:0] samples,
  output logic                                        sample_take,
  output logic                                        nco_sync,
  conv_link_if.tx                                     link
);
  localparam int SW = transport_pkg::SAMPLE_W;

  if (LANES < 1 || LANES > 8) begin : g_bad_lanes
    $error("LANES must be 1 to 8");
  end
  if (EMB_LEN < 1 || EMB_LEN > 16) begin : g_bad_emb
    $error("EMB_LEN must be 1 to 16");
  end

  transport_pkg::link_state_t st_r, st_nxt;
  logic [31:0]        prdata_r;
  logic               pready_r, pslverr_r;
  logic [1:0]         mode_r;
  logic               scr_r, nco_en_r, fec_r, sref_seen_r;
  logic [7:0]         klen_r;
  logic               sync_m_r, sync_s_r, sync_d_r;
  logic               sref_m_r, sref_s_r, sref_d_r;
  logic [1:0]         tp_cnt_r;
  logic [7:0]         frm_cnt_r;
  logic [2:0]         blk_oct_r;
  logic [4:0]         mb_cnt_r;
  logic [3:0]         emb_cnt_r;
  logic [1:0]         ilas_cnt_r;
  logic [LANES*SW-1:0] sample_r;
  logic               sample_take_r, nco_sync_r, hdr_valid_r;
  logic [LANES*8-1:0] octet_r, octet_nxt;
  logic [LANES-1:0]   k_r, k_nxt;

  // APB decode; the answer flops load in the setup phase, so every access ends with no wait state
  wire setup     = psel & ~penable;
  wire access    = psel & penable & pready_r;
  wire wr        = access & pwrite;
  wire hit_ctrl  = (paddr == transport_pkg::A_CTRL);
  wire hit_stat  = (paddr == transport_pkg::A_STAT);
  wire hit_klen  = (paddr == transport_pkg::A_KLEN);
  wire hit_any   = hit_ctrl | hit_stat | hit_klen;
  wire wr_ctrl   = wr & hit_ctrl;
  wire restart   = wr_ctrl & pwdata[transport_pkg::C_RESTART];
  wire mode_chg  = wr_ctrl & (pwdata[1:0] != mode_r);
  wire sref_clr  = wr & hit_stat & pwdata[transport_pkg::S_SREF];

  // Mode decode: the single mode field fixes code, F and framing
  wire       is64     = transport_pkg::mode_is64(mode_r);
  wire [1:0] f_len    = transport_pkg::mode_f(mode_r);
  wire       scr_on   = is64 | scr_r;
  wire       fec_act  = fec_r & is64;
  wire       tp_last  = (tp_cnt_r == f_len - 2'h1);
  wire       frm_last = (frm_cnt_r == klen_r);
  wire       blk_last = (blk_oct_r == transport_pkg::BLK_LAST);
  wire       mb_last  = (mb_cnt_r == transport_pkg::MB_LAST);
  wire       emb_last = (emb_cnt_r == 4'(EMB_LEN - 1));
  wire       lmfc_nxt = tp_last & frm_last;
  wire       sref_rise = sref_s_r & ~sref_d_r;
  wire       sync_fall = ~sync_s_r & sync_d_r;
  wire       reinit    = restart | mode_chg;

  wire [31:0] stat_val = {27'h0, fec_act, sref_seen_r, sync_s_r, st_r};
  wire [31:0] ctrl_val = {27'h0, fec_r, nco_en_r, scr_r, mode_r};
  wire [31:0] rd_val   = hit_ctrl ? ctrl_val :
                         hit_stat ? stat_val :
                         hit_klen ? {24'h0, klen_r} : 32'h0;

  // Bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= (setup & ~pwrite) ? rd_val : 32'h0;
      pslverr_r <= setup & ~hit_any;
    end
  end

  // Software settings; SYSREF seen flag keeps a new capture over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r      <= transport_pkg::MODE_RST;
      scr_r       <= 1'b0;
      nco_en_r    <= 1'b0;
      fec_r       <= 1'b0;
      klen_r      <= transport_pkg::KLEN_RST;
      sref_seen_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_r   <= pwdata[1:0];
        scr_r    <= pwdata[transport_pkg::C_SCR];
        nco_en_r <= pwdata[transport_pkg::C_NCO];
        fec_r    <= pwdata[transport_pkg::C_FEC];
      end
      if (wr & hit_klen) begin
        klen_r <= pwdata[7:0];
      end
      sref_seen_r <= sref_rise | (sref_seen_r & ~sref_clr);
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
      sref_m_r <= 1'b0;
      sref_s_r <= 1'b0;
      sref_d_r <= 1'b0;
    end else begin
      sync_m_r <= link.sync_n;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
      sref_m_r <= sysref;
      sref_s_r <= sref_m_r;
      sref_d_r <= sref_s_r;
    end
  end

  // Frame, multiframe, block, multiblock and extended multiblock counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_cnt_r  <= 2'h0;
      frm_cnt_r <= 8'h0;
      blk_oct_r <= 3'h0;
      mb_cnt_r  <= 5'h0;
      emb_cnt_r <= 4'h0;
    end else if (sref_rise) begin
      tp_cnt_r  <= 2'h0;
      frm_cnt_r <= 8'h0;
      blk_oct_r <= 3'h0;
      mb_cnt_r  <= 5'h0;
      emb_cnt_r <= 4'h0;
    end else begin
      tp_cnt_r  <= tp_last ? 2'h0 : tp_cnt_r + 2'h1;
      if (tp_last) begin
        frm_cnt_r <= frm_last ? 8'h0 : frm_cnt_r + 8'h1;
      end
      blk_oct_r <= blk_oct_r + 3'h1;
      if (blk_last) begin
        mb_cnt_r <= mb_cnt_r + 5'h1;
        if (mb_last) begin
          emb_cnt_r <= emb_last ? 4'h0 : emb_cnt_r + 4'h1;
        end
      end
    end
  end

  // Link bring-up; in 64b/66b the sync input never steers the state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      transport_pkg::ST_CGS: begin
        if (is64) begin
          st_nxt = transport_pkg::ST_DATA;
        end else if (sync_s_r) begin
          st_nxt = transport_pkg::ST_WAIT;
        end
      end
      transport_pkg::ST_WAIT: begin
        if (lmfc_nxt) begin
          st_nxt = transport_pkg::ST_ILAS;
        end
      end
      transport_pkg::ST_ILAS: begin
        if (lmfc_nxt && ilas_cnt_r == transport_pkg::ILAS_LAST) begin
          st_nxt = transport_pkg::ST_DATA;
        end
      end
      transport_pkg::ST_DATA: st_nxt = transport_pkg::ST_DATA;
      default: st_nxt = transport_pkg::ST_CGS;
    endcase
    if (reinit) begin
      st_nxt = transport_pkg::ST_CGS;
    end else if (!is64 && !sync_s_r) begin
      st_nxt = transport_pkg::ST_CGS;
    end
  end

  // State, alignment count and sample capture once per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= transport_pkg::ST_CGS;
      ilas_cnt_r    <= 2'h0;
      sample_r      <= '0;
      sample_take_r <= 1'b0;
      nco_sync_r    <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r != transport_pkg::ST_ILAS) begin
        ilas_cnt_r <= 2'h0;
      end else if (lmfc_nxt) begin
        ilas_cnt_r <= ilas_cnt_r + 2'h1;
      end
      if (tp_last) begin
        sample_r <= samples;
      end
      sample_take_r <= tp_last;
      nco_sync_r    <= is64 & nco_en_r & sync_fall;
    end
  end

  wire in_data = (st_r == transport_pkg::ST_DATA);
  wire in_ilas = (st_r == transport_pkg::ST_ILAS);
  wire [7:0] cfg_oct = {3'h0, fec_r, nco_en_r, scr_r, mode_r};

  // Per lane: map, scramble and pick the character; all lanes share counters
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire [SW-1:0] smp  = sample_r[l*SW +: SW];
    wire [7:0]    pay  = (tp_cnt_r == 2'h0) ? smp[11:4] : {smp[3:0], 4'h0};
    wire          mf_first = (tp_cnt_r == 2'h0) && (frm_cnt_r == 8'h0);
    wire          cfg_pos  = (ilas_cnt_r == 2'h1) && (frm_cnt_r == 8'h1);
    wire [7:0]    ilas_oct = mf_first ? transport_pkg::K28_0 :
                             lmfc_nxt ? transport_pkg::K28_3 :
                             cfg_pos ? cfg_oct : frm_cnt_r;
    wire          ilas_k   = mf_first | lmfc_nxt;
    wire [7:0]    scr_oct;

    link_scrambler u_scr (
      .pclk       (pclk),
      .presetn    (presetn),
      .clear      (~in_data | reinit),
      .mode64     (is64),
      .descramble (1'b0),
      .enable     (scr_on & in_data),
      .din        (pay),
      .dout       (scr_oct)
    );

    assign octet_nxt[l*8 +: 8] = in_data ? scr_oct :
                                 in_ilas ? ilas_oct : transport_pkg::K28_5;
    assign k_nxt[l] = in_data ? 1'b0 : (in_ilas ? ilas_k : 1'b1);
  end

  // Link output flops; header rides with the first octet of each block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      octet_r     <= '0;
      k_r         <= '0;
      hdr_valid_r <= 1'b0;
    end else begin
      octet_r     <= octet_nxt;
      k_r         <= k_nxt;
      hdr_valid_r <= is64 & in_data & (blk_oct_r == 3'h0);
    end
  end

  assign link.octet     = octet_r;
  assign link.ctrl_k    = k_r;
  assign link.hdr_valid = hdr_valid_r;
  assign link.sync_hdr  = transport_pkg::SH_DATA;
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign sample_take    = sample_take_r;
  assign nco_sync       = nco_sync_r;
endmodule : tx_transport_end
`default_nettype wire

// File: verilog/rx_logic_end.sv
// Receiving logic end: sync request, CGS, alignment, header lock, descramble
`default_nettype none
module rx_logic_end #(
  parameter int LANES = 2
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               enc64,
  input  wire logic               scr_en,
  input  wire logic               resync,
  output logic [LANES*8-1:0]      rx_octets,
  output logic                    rx_valid,
  output logic                    locked,
  conv_link_if.rx                 link
);
  if (LANES < 1 || LANES > 8) begin : g_bad_lanes
    $error("LANES must be 1 to 8");
  end

  transport_pkg::link_state_t st_r, st_nxt;
  logic [2:0]         cgs_cnt_r, hdr_cnt_r;
  logic [1:0]         a_cnt_r;
  logic               sync_n_r, locked_r, valid_r;
  logic [LANES*8-1:0] octets_r, plain;

  wire all_comma = (&link.ctrl_k) &&
                   (link.octet == {LANES{transport_pkg::K28_5}});
  wire a_seen    = link.ctrl_k[0] && (link.octet[7:0] == transport_pkg::K28_3);
  wire in_data   = (st_r == transport_pkg::ST_DATA);
  wire hdr_ok    = link.hdr_valid && (link.sync_hdr == transport_pkg::SH_DATA);
  wire hdr_bad   = link.hdr_valid && (link.sync_hdr != transport_pkg::SH_DATA);

  // Bring-up: hold sync low until four commas, then follow the alignment sequence
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      transport_pkg::ST_CGS: begin
        if (enc64) begin
          st_nxt = transport_pkg::ST_DATA;
        end else if (all_comma && cgs_cnt_r == transport_pkg::CGS_NEED - 3'h1) begin
          st_nxt = transport_pkg::ST_ILAS;
        end
      end
      transport_pkg::ST_ILAS: begin
        if (a_seen && a_cnt_r == transport_pkg::ILAS_LAST) begin
          st_nxt = transport_pkg::ST_DATA;
        end
      end
      transport_pkg::ST_DATA: st_nxt = transport_pkg::ST_DATA;
      default: st_nxt = transport_pkg::ST_CGS;
    endcase
    if (resync) begin
      st_nxt = transport_pkg::ST_CGS;
    end
  end

  // Counters and sync request; 64b/66b locks on headers alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= transport_pkg::ST_CGS;
      cgs_cnt_r <= 3'h0;
      a_cnt_r   <= 2'h0;
      hdr_cnt_r <= 3'h0;
      sync_n_r  <= 1'b0;
      locked_r  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cgs_cnt_r <= (all_comma && st_r == transport_pkg::ST_CGS) ? cgs_cnt_r + 3'h1 : 3'h0;
      a_cnt_r   <= (st_r != transport_pkg::ST_ILAS) ? 2'h0 : a_cnt_r + {1'b0, a_seen};
      sync_n_r  <= enc64 | (st_nxt != transport_pkg::ST_CGS);
      if (!enc64 || resync || hdr_bad) begin
        hdr_cnt_r <= 3'h0;
      end else if (hdr_ok && hdr_cnt_r != transport_pkg::LOCK_NEED) begin
        hdr_cnt_r <= hdr_cnt_r + 3'h1;
      end
      locked_r <= enc64 ? (hdr_cnt_r == transport_pkg::LOCK_NEED) : in_data;
    end
  end

  // Descramblers follow the line with no seed exchange
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    link_scrambler u_dsc (
      .pclk       (pclk),
      .presetn    (presetn),
      .clear      (~in_data),
      .mode64     (enc64),
      .descramble (1'b1),
      .enable     ((enc64 | scr_en) & in_data),
      .din        (link.octet[l*8 +: 8]),
      .dout       (plain[l*8 +: 8])
    );
  end

  // Output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      octets_r <= '0;
      valid_r  <= 1'b0;
    end else begin
      octets_r <= plain;
      valid_r  <= in_data & (enc64 ? locked_r : ~(|link.ctrl_k));
    end
  end

  assign link.sync_n = sync_n_r;
  assign rx_octets   = octets_r;
  assign rx_valid    = valid_r;
  assign locked      = locked_r;
endmodule : rx_logic_end
`default_nettype wire

// File: tb/link_properties.sv
// Concurrent checks on the link that joins the transmit end to the receive end
`default_nettype none
module link_properties #(
  parameter int LANES = 2
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               enc64,
  input wire logic               sysref,
  input wire logic               sync_n,
  input wire logic [LANES*8-1:0] octet,
  input wire logic [LANES-1:0]   ctrl_k,
  input wire logic [1:0]         sync_hdr,
  input wire logic               hdr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet_r;

  // Block phase may jump after a timing reference, so spacing checks pause a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_r <= 4'h0;
    else if (sysref) quiet_r <= 4'hf;
    else if (quiet_r != 4'h0) quiet_r <= quiet_r - 4'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Commas on every lane at once
  sequence comma_s;
    (&ctrl_k) && (octet == {LANES{transport_pkg::K28_5}});
  endsequence
  sequence low_s;
    !enc64 && !sync_n;
  endsequence

  property hdr_space_p;
    @(posedge pclk) disable iff (!presetn || !enc64 || sysref || quiet_r != 4'h0)
      hdr_valid |=> (!hdr_valid) [*7] ##1 hdr_valid;
  endproperty
  property hdr_nok_p;
    @(posedge pclk) disable iff (!presetn || !enc64)
      hdr_valid |-> (ctrl_k == '0) [*8];
  endproperty

  hdr_const_a: assert property (sync_hdr == transport_pkg::SH_DATA)
    else $error("sync header not of data type");
  comma_hold_a: assert property (low_s [*8] |-> comma_s)
    else $error("no commas while sync request held low");
  no_ilas_a: assert property (low_s [*6] |-> !(ctrl_k[0] && octet[7:0] == 8'h1c))
    else $error("alignment start while sync request low");
  rose_comma_a: assert property (!enc64 && $rose(sync_n) |=> comma_s [*2])
    else $error("commas stopped too soon after sync release");
  lane_align_a: assert property (ctrl_k == '0 || (&ctrl_k && octet == {LANES{octet[7:0]}}))
    else $error("lanes not aligned on control characters");
  k_values_a: assert property (ctrl_k[0] |-> octet[7:0] inside {8'hbc, 8'h1c, 8'h7c})
    else $error("unexpected control character value");
  hdr_space_a: assert property (hdr_space_p)
    else $error("block header spacing not eight octets");
  hdr_nok_a: assert property (hdr_nok_p)
    else $error("control character inside a block");
endmodule : link_properties
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench joining the transmit end and the receive end over one link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 2;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref  = 1'b0;
  logic [23:0] samples = 24'habc123;
  logic        enc64   = 1'b0;
  logic        scr_en  = 1'b0;
  logic        resync  = 1'b0;
  logic [15:0] rx_octets;
  logic        rx_valid;
  logic        locked;
  logic        sample_take;
  logic        nco_sync;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  conv_link_if #(.LANES(LANES)) i_conv_link_if ();
  tx_transport_end #(.LANES(LANES), .EMB_LEN(1)) i_tx_transport_end (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref(sysref), .samples(samples), .sample_take(sample_take), .nco_sync(nco_sync),
    .link(i_conv_link_if));
  rx_logic_end #(.LANES(LANES)) i_rx_logic_end (
    .pclk(pclk), .presetn(presetn), .enc64(enc64), .scr_en(scr_en), .resync(resync),
    .rx_octets(rx_octets), .rx_valid(rx_valid), .locked(locked), .link(i_conv_link_if));
  link_properties #(.LANES(LANES)) i_link_properties (
    .pclk(pclk), .presetn(presetn), .enc64(enc64), .sysref(sysref),
    .sync_n(i_conv_link_if.sync_n), .octet(i_conv_link_if.octet),
    .ctrl_k(i_conv_link_if.ctrl_k), .sync_hdr(i_conv_link_if.sync_hdr),
    .hdr_valid(i_conv_link_if.hdr_valid));

  always #25 pclk = ~pclk;

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("mismatch timeout expected end seen hang");
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Answer is taken at the rising edge where pready is sampled high; one idle edge follows
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] mask,
                    input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q & mask);
  endtask : rd

  // New setting, receiver restart, then a bounded wait for data
  task automatic relink(input logic [31:0] ctrl);
    int n;
    wr(transport_pkg::A_CTRL, ctrl);
    resync <= 1'b1;
    @(posedge pclk);
    resync <= 1'b0;
    repeat (8) @(posedge pclk);
    n = 0;
    @(negedge pclk);
    while (rx_valid !== 1'b1 && n < 600) begin
      @(negedge pclk);
      n++;
    end
    chk("rx_valid", 32'h1, rx_valid);
    @(posedge pclk);
  endtask : relink

  // Received pair in either order; the wire shows plain octets only when unscrambled
  task automatic data_chk(input logic [15:0] e0, input logic [15:0] e1, input logic scramble_enable,
                          input int ns);
    logic [15:0] a;
    int          nd;
    int          nt;
    nd = 0;
    nt = 0;
    @(negedge pclk);
    a = rx_octets;
    @(negedge pclk);
    chk("rx pair", 32'h1, (a === e0 && rx_octets === e1) || (a === e1 && rx_octets === e0));
    repeat (8) begin
      @(negedge pclk);
      if (i_conv_link_if.octet !== e0 && i_conv_link_if.octet !== e1) nd++;
      if (sample_take === 1'b1) nt++;
    end
    chk("wire scrambled", scramble_enable, nd != 0);
    chk("sample_take", ns, nt);
    @(posedge pclk);
  endtask : data_chk

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd("ctrl", transport_pkg::A_CTRL, 32'h3f, 32'h0);
    rd("klen", transport_pkg::A_KLEN, 32'hff, 32'h1f);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, q);
  endtask : t_reset

  task automatic t_8b();
    wr(transport_pkg::A_KLEN, 32'h3);
    relink(32'h0);
    data_chk(16'hab12, 16'hab12, 1'b0, 8);
    rd("state", transport_pkg::A_STAT, 32'h3, 32'h3);
    relink(32'h1);
    data_chk(16'hab12, 16'hc030, 1'b0, 4);
    scr_en <= 1'b1;
    relink(32'h5);
    data_chk(16'hab12, 16'hc030, 1'b1, 4);
  endtask : t_8b

  task automatic t_64();
    enc64 <= 1'b1;
    scr_en <= 1'b0;
    relink(32'h1a);
    data_chk(16'hab12, 16'hab12, 1'b1, 8);
    chk("locked", 32'h1, locked);
    rd("fec", transport_pkg::A_STAT, 32'h10, 32'h10);
    resync <= 1'b1;
    @(posedge pclk);
    resync <= 1'b0;
    repeat (6) @(posedge pclk);
    rd("state 64", transport_pkg::A_STAT, 32'h3, 32'h3);
  endtask : t_64

  // Header phase after each timing pulse must not depend on when the pulse came
  task automatic t_sref();
    int off [3];
    for (int i = 0; i < 3; i++) begin
      repeat (i + 1) @(posedge pclk);
      sysref <= 1'b1;
      repeat (4) @(posedge pclk);
      sysref <= 1'b0;
      off[i] = 4;
      @(negedge pclk);
      while (i_conv_link_if.hdr_valid !== 1'b1 && off[i] < 40) begin
        @(negedge pclk);
        off[i]++;
      end
      @(posedge pclk);
    end
    chk("sysref phase 1", off[0], off[1]);
    chk("sysref phase 2", off[0], off[2]);
    rd("sysref seen", transport_pkg::A_STAT, 32'h8, 32'h8);
    wr(transport_pkg::A_STAT, 32'h8);
    rd("sysref clear", transport_pkg::A_STAT, 32'h8, 32'h0);
  endtask : t_sref

  // Sync request falls while the transmitter is still in 64b/66b: one phase-sync pulse
  task automatic t_back();
    enc64 <= 1'b0;
    resync <= 1'b1;
    @(posedge pclk);
    resync <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("nco_sync", 32'h1, nco_sync);
    @(posedge pclk);
    relink(32'h20);
    rd("restart reads 0", transport_pkg::A_CTRL, 32'h3f, 32'h0);
    data_chk(16'hab12, 16'hab12, 1'b0, 8);
  endtask : t_back

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_8b();
    t_64();
    t_sref();
    t_back();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
